// ---- mcs_defs.svh ----
// Summary of operation
// - reset holds execute, clears opcode, flags, selectors
// - reset sets interrupt accept, suppresses both pulses
// - init cycle drives zero, register zero addressed
// - idle repeats execute reading register zero
// - load mode suppresses early pulse in execute cycles only, awaits DMA
// - DMA-in wins over simultaneous DMA-out
// - load advance reads via N, increments it
// - pointer load reads via X, increments it
// - pointer store writes accumulator, decrements X register
// - shift right: lsb to carry, zero in
// - port output reads via X, increments it
// - load immediate reads via program counter, increments
// - DMA-in writes bus byte at register zero
// - DMA-out reads register zero onto bus
// - interrupt saves X,P, sets 2,1, disables
`ifndef MCS_DEFS_SVH
`define MCS_DEFS_SVH

`define MCS_AXI_AW 8
`define MCS_CTRL_OFF 8'h00
`define MCS_STAT_OFF 8'h04
`define MCS_CORE_OFF 8'h08
`define MCS_CTRL_LOAD_BIT 0
`define MCS_RESP_OKAY 2'h0
`define MCS_RESP_SLVERR 2'h2

`define MCS_PH_EARLY 2'h1
`define MCS_PH_MID 2'h2
`define MCS_PH_LATE 2'h3

`define MCS_RST_IRQ_ACCEPT 1'b1
`define MCS_IRQ_X 4'h2
`define MCS_IRQ_P 4'h1

`define MCS_GRP_LOAD_N 4'h0
`define MCS_GRP_INC 4'h1
`define MCS_GRP_DEC 4'h2
`define MCS_LOAD_ADVANCE_OP 4'h4
`define MCS_GRP_STORE_N 4'h5
`define MCS_GRP_IO 4'h6
`define MCS_GRP_SEVEN 4'h7
`define MCS_GRP_SET_P 4'hD
`define MCS_GRP_SET_X 4'hE
`define MCS_GRP_ALU 4'hF

`define MCS_IDLE_OP 4'h0
`define MCS_N_INC_X 4'h0
`define MCS_N_IO_NONE 4'h8
`define MCS_LOAD_BY_POINTER_OP 4'h2
`define MCS_STORE_DEC_BY_POINTER_OP 4'h3
`define MCS_N_RESET_Q 4'hA
`define MCS_N_SET_Q 4'hB
`define MCS_N_LOAD_X 4'h0
`define MCS_SHIFT_RIGHT_OP 4'h6
`define MCS_LOAD_IMMEDIATE_OP 4'h8

`endif

// ---- mcs_mem_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// ====================
// memory and dma device on the shared data bus
module mcs_mem_model #(
    parameter logic [7:0] DMA_BYTE = 8'hC3
) (
    input wire logic aclk,
    input wire logic [15:0] mem_addr,
    input wire logic [7:0] data_bus_out,
    input wire logic data_bus_oe,
    input wire logic memory_read_strobe,
    input wire logic memory_write_strobe,
    input wire logic [3:0] machine_state,
    output logic [7:0] data_bus_in
);
    logic [7:0] mem [256];
    logic [7:0] last = 8'h00;
    initial begin
        foreach (mem[i]) mem[i] = 8'h00;
        mem[0] = 8'hF8;
        mem[1] = 8'h5B;
        mem[2] = 8'hF6;
        mem[3] = 8'h7B;
        mem[4] = 8'h61;
    end
    // an undriven bus shows no stale byte, so a missed read cannot pass
    always_comb begin
        if (data_bus_oe) data_bus_in = data_bus_out;
        else if (memory_write_strobe && machine_state == 4'h4) data_bus_in = DMA_BYTE;
        else if (memory_read_strobe) data_bus_in = mem[mem_addr[7:0]];
        else data_bus_in = ~last;
    end
    always @(posedge aclk) begin
        last <= data_bus_in;
        if (memory_write_strobe) mem[mem_addr[7:0]] <= data_bus_in;
    end
endmodule
`default_nettype wire

// ---- mcs_pkg.sv ----
`include "mcs_defs.svh"

package mcs_pkg;

    typedef enum logic [3:0] {
        fetch_state = 4'h1,
        execute_state = 4'h2,
        dma_state = 4'h4,
        irq_state = 4'h8
    } mcs_state_t;

    typedef enum logic [1:0] {
        rf_hold = 2'h0,
        rf_inc = 2'h1,
        rf_dec = 2'h2,
        rf_clr = 2'h3
    } mcs_rf_op_t;

    typedef enum logic [1:0] {
        sel_n = 2'h0,
        sel_x = 2'h1,
        sel_p = 2'h2,
        sel_zero = 2'h3
    } mcs_ptr_t;

    typedef struct packed {
        mcs_state_t st;
        logic [1:0] ph;
        logic init;
        logic idle;
        logic dma_in_cyc;
        logic load_mode;
        logic [3:0] upper_opcode_half;
        logic [3:0] low_code_field;
        logic [3:0] operand_pointer_select;
        logic [3:0] counter_choice;
        logic [7:0] pushed_pair_hold;
        logic [7:0] accumulator;
        logic carry_flag;
        logic output_flag;
        logic irq_accept_flag;
        logic [15:0] addr;
        logic [7:0] dout;
        logic doe;
        logic rd;
        logic wr;
        logic early;
        logic late;
        logic [2:0] io_sel;
        logic aw_got;
        logic w_got;
        logic [`MCS_AXI_AW-1:0] aw_addr;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } mcs_core_t;

    localparam mcs_core_t MCS_CORE_RESET = '{
        st: execute_state,
        init: 1'b1,
        irq_accept_flag: `MCS_RST_IRQ_ACCEPT,
        default: '0
    };

endpackage

// ---- mcs_scratchpad.sv ----
`timescale 1ns/1ps
`default_nettype none

// =====================================================================
// scratchpad pointer registers with in-place increment and decrement
module mcs_scratchpad #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 16,
    parameter int AW = 4
) (
    input wire logic aclk,
    input wire logic [AW-1:0] raddr,
    output logic [WIDTH-1:0] rdata,
    input wire logic we,
    input wire mcs_pkg::mcs_rf_op_t op
);
    // contents are not reset: only register zero is cleared, by the init cycle
    logic [WIDTH-1:0] regs [DEPTH];

    assign rdata = regs[raddr];

    always_ff @(posedge aclk) begin
        if (we) begin
            case (op)
                mcs_pkg::rf_inc: regs[raddr] <= rdata + WIDTH'(1);
                mcs_pkg::rf_dec: regs[raddr] <= rdata - WIDTH'(1);
                mcs_pkg::rf_clr: regs[raddr] <= '0;
                default: regs[raddr] <= rdata;
            endcase
        end
    end
endmodule

`default_nettype wire

// ---- mcs_sequencer.sv ----
// The implementer's own choices: the AXI4-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.svh"

module mcs_sequencer (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic awvalid,
    output logic awready,
    input wire logic [`MCS_AXI_AW-1:0] awaddr,
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    input wire logic arvalid,
    output logic arready,
    input wire logic [`MCS_AXI_AW-1:0] araddr,
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic [15:0] mem_addr,
    output logic [7:0] data_bus_out,
    output logic data_bus_oe,
    input wire logic [7:0] data_bus_in,
    output logic memory_read_strobe,
    output logic memory_write_strobe,
    output logic early_pulse,
    output logic late_pulse,
    output logic [3:0] machine_state,
    output logic [2:0] io_select,
    output logic output_flag,
    input wire logic dma_in_req,
    input wire logic dma_out_req,
    input wire logic irq_req
);
    mcs_pkg::mcs_core_t s;
    mcs_pkg::mcs_core_t next_s;
    mcs_pkg::mcs_ptr_t ptr;
    mcs_pkg::mcs_rf_op_t rf_op;
    logic mem_rd;
    logic mem_wr;
    logic drv_acc;
    logic drv_zero;
    logic ld_acc;
    logic end_cycle;
    logic exec_op;
    logic idle_now;
    logic [3:0] rf_addr;
    logic [15:0] rf_data;

    // =================================================================
    // pointer registers
    mcs_scratchpad #(.WIDTH(16), .DEPTH(16), .AW(4)) u_mcs_scratchpad (
        .aclk(aclk),
        .raddr(rf_addr),
        .rdata(rf_data),
        .we(end_cycle && rf_op != mcs_pkg::rf_hold && aresetn),
        .op(rf_op)
    );

    // =================================================================
    // what the current machine cycle does on the buses
    always_comb begin
        ptr = mcs_pkg::sel_n;
        rf_op = mcs_pkg::rf_hold;
        mem_rd = 1'b0;
        mem_wr = 1'b0;
        drv_acc = 1'b0;
        drv_zero = 1'b0;
        ld_acc = 1'b0;
        end_cycle = s.ph == `MCS_PH_LATE;
        exec_op = s.st == mcs_pkg::execute_state && !s.init && !s.idle && !s.load_mode;
        idle_now = s.st == mcs_pkg::execute_state && (s.idle || (exec_op
                   && s.upper_opcode_half == `MCS_GRP_LOAD_N
                   && s.low_code_field == `MCS_IDLE_OP));
        case (s.st)
            mcs_pkg::fetch_state: begin
                ptr = mcs_pkg::sel_p;
                mem_rd = 1'b1;
                rf_op = mcs_pkg::rf_inc;
            end
            mcs_pkg::dma_state: begin
                ptr = mcs_pkg::sel_zero;
                rf_op = mcs_pkg::rf_inc;
                mem_wr = s.dma_in_cyc;
                mem_rd = !s.dma_in_cyc;
            end
            mcs_pkg::execute_state: begin
                if (s.init) begin
                    ptr = mcs_pkg::sel_zero;
                    drv_zero = 1'b1;
                    rf_op = mcs_pkg::rf_clr;
                end else if (s.idle || s.load_mode) begin
                    // load mode reads at register zero, the location after the last loaded byte
                    ptr = mcs_pkg::sel_zero;
                    mem_rd = 1'b1;
                end else begin
                    case (s.upper_opcode_half)
                        `MCS_GRP_LOAD_N: begin
                            mem_rd = 1'b1;
                            ld_acc = s.low_code_field != `MCS_IDLE_OP;
                        end
                        `MCS_GRP_INC: rf_op = mcs_pkg::rf_inc;
                        `MCS_GRP_DEC: rf_op = mcs_pkg::rf_dec;
                        `MCS_LOAD_ADVANCE_OP: begin
                            mem_rd = 1'b1;
                            ld_acc = 1'b1;
                            rf_op = mcs_pkg::rf_inc;
                        end
                        `MCS_GRP_STORE_N: begin
                            mem_wr = 1'b1;
                            drv_acc = 1'b1;
                        end
                        `MCS_GRP_IO: begin
                            ptr = mcs_pkg::sel_x;
                            if (s.low_code_field == `MCS_N_INC_X) begin
                                rf_op = mcs_pkg::rf_inc;
                            end else if (!s.low_code_field[3]) begin
                                mem_rd = 1'b1;
                                rf_op = mcs_pkg::rf_inc;
                            end else if (s.low_code_field != `MCS_N_IO_NONE) begin
                                // input: the port drives the bus into memory and accumulator
                                mem_wr = 1'b1;
                                ld_acc = 1'b1;
                            end
                        end
                        `MCS_GRP_SEVEN: begin
                            ptr = mcs_pkg::sel_x;
                            if (s.low_code_field == `MCS_LOAD_BY_POINTER_OP) begin
                                mem_rd = 1'b1;
                                ld_acc = 1'b1;
                                rf_op = mcs_pkg::rf_inc;
                            end else if (s.low_code_field == `MCS_STORE_DEC_BY_POINTER_OP) begin
                                mem_wr = 1'b1;
                                drv_acc = 1'b1;
                                rf_op = mcs_pkg::rf_dec;
                            end
                        end
                        `MCS_GRP_ALU: begin
                            if (s.low_code_field == `MCS_N_LOAD_X) begin
                                ptr = mcs_pkg::sel_x;
                                mem_rd = 1'b1;
                                ld_acc = 1'b1;
                            end else if (s.low_code_field == `MCS_LOAD_IMMEDIATE_OP) begin
                                ptr = mcs_pkg::sel_p;
                                mem_rd = 1'b1;
                                ld_acc = 1'b1;
                                rf_op = mcs_pkg::rf_inc;
                            end else begin
                                ptr = mcs_pkg::sel_x;
                            end
                        end
                        default: ptr = mcs_pkg::sel_n;
                    endcase
                end
            end
            default: ptr = mcs_pkg::sel_n;
        endcase
        case (ptr)
            mcs_pkg::sel_x: rf_addr = s.operand_pointer_select;
            mcs_pkg::sel_p: rf_addr = s.counter_choice;
            mcs_pkg::sel_zero: rf_addr = 4'h0;
            default: rf_addr = s.low_code_field;
        endcase
    end

    // =================================================================
    // next state: bus outputs, machine cycle sequencing, register slave
    assign awready = !s.aw_got && !s.bvalid;
    assign wready = !s.w_got && !s.bvalid;
    assign arready = !s.rvalid;

    always_comb begin
        next_s = s;
        next_s.ph = s.ph + 2'h1;
        // outputs are registered, so they follow the state one clock late
        next_s.addr = rf_data;
        next_s.rd = mem_rd;
        next_s.wr = mem_wr && (s.ph == `MCS_PH_EARLY || s.ph == `MCS_PH_MID);
        next_s.doe = drv_acc || drv_zero;
        next_s.dout = drv_zero ? 8'h00 : s.accumulator;
        next_s.early = next_s.ph == `MCS_PH_EARLY
                       && !(s.load_mode && s.st == mcs_pkg::execute_state);
        next_s.late = next_s.ph == `MCS_PH_LATE;
        next_s.io_sel = (exec_op && s.upper_opcode_half == `MCS_GRP_IO)
                        ? s.low_code_field[2:0] : 3'h0;
        if (end_cycle) begin
            if (ld_acc) begin
                next_s.accumulator = data_bus_in;
            end
            case (s.st)
                mcs_pkg::fetch_state: begin
                    next_s.upper_opcode_half = data_bus_in[7:4];
                    next_s.low_code_field = data_bus_in[3:0];
                    next_s.st = mcs_pkg::execute_state;
                end
                mcs_pkg::irq_state: begin
                    next_s.pushed_pair_hold = {s.operand_pointer_select, s.counter_choice};
                    next_s.operand_pointer_select = `MCS_IRQ_X;
                    next_s.counter_choice = `MCS_IRQ_P;
                    next_s.irq_accept_flag = 1'b0;
                    next_s.st = mcs_pkg::fetch_state;
                end
                default: begin
                    next_s.init = 1'b0;
                    if (exec_op) begin
                        case (s.upper_opcode_half)
                            `MCS_GRP_SET_P: next_s.counter_choice = s.low_code_field;
                            `MCS_GRP_SET_X: next_s.operand_pointer_select = s.low_code_field;
                            `MCS_GRP_SEVEN: begin
                                if (s.low_code_field == `MCS_N_SET_Q) begin
                                    next_s.output_flag = 1'b1;
                                end else if (s.low_code_field == `MCS_N_RESET_Q) begin
                                    next_s.output_flag = 1'b0;
                                end
                            end
                            `MCS_GRP_ALU: begin
                                if (s.low_code_field == `MCS_SHIFT_RIGHT_OP) begin
                                    next_s.carry_flag = s.accumulator[0];
                                    next_s.accumulator = {1'b0, s.accumulator[7:1]};
                                end
                            end
                            default: next_s.output_flag = s.output_flag;
                        endcase
                    end
                    // requests are sampled only here, at the end of execute or DMA
                    if (dma_in_req) begin
                        next_s.st = mcs_pkg::dma_state;
                        next_s.dma_in_cyc = 1'b1;
                        next_s.idle = 1'b0;
                    end else if (dma_out_req) begin
                        next_s.st = mcs_pkg::dma_state;
                        next_s.dma_in_cyc = 1'b0;
                        next_s.idle = 1'b0;
                    end else if (s.load_mode) begin
                        next_s.st = mcs_pkg::execute_state;
                    end else if (irq_req && s.irq_accept_flag) begin
                        next_s.st = mcs_pkg::irq_state;
                        next_s.idle = 1'b0;
                    end else if (idle_now) begin
                        next_s.st = mcs_pkg::execute_state;
                        next_s.idle = 1'b1;
                    end else begin
                        next_s.st = mcs_pkg::fetch_state;
                        next_s.idle = 1'b0;
                    end
                end
            endcase
        end
        if (awvalid && awready) begin
            next_s.aw_got = 1'b1;
            next_s.aw_addr = awaddr;
        end
        if (wvalid && wready) begin
            next_s.w_got = 1'b1;
            next_s.w_data = wdata;
            next_s.w_strb = wstrb;
        end
        if (s.aw_got && s.w_got) begin
            next_s.aw_got = 1'b0;
            next_s.w_got = 1'b0;
            next_s.bvalid = 1'b1;
            if (s.aw_addr == `MCS_CTRL_OFF) begin
                next_s.bresp = `MCS_RESP_OKAY;
                if (s.w_strb[0]) begin
                    next_s.load_mode = s.w_data[`MCS_CTRL_LOAD_BIT];
                end
            end else begin
                next_s.bresp = `MCS_RESP_SLVERR;
            end
        end
        if (s.bvalid && bready) begin
            next_s.bvalid = 1'b0;
        end
        if (s.rvalid && rready) begin
            next_s.rvalid = 1'b0;
        end
        if (arvalid && arready) begin
            next_s.rvalid = 1'b1;
            next_s.rresp = `MCS_RESP_OKAY;
            case (araddr)
                `MCS_CTRL_OFF: next_s.rdata = 32'(s.load_mode);
                `MCS_STAT_OFF: next_s.rdata = 32'({s.idle, s.dma_in_cyc, s.irq_accept_flag,
                    s.carry_flag, s.output_flag, s.load_mode, s.ph, s.st});
                `MCS_CORE_OFF: next_s.rdata = {s.pushed_pair_hold, s.accumulator,
                    s.upper_opcode_half, s.low_code_field,
                    s.operand_pointer_select, s.counter_choice};
                default: begin
                    next_s.rdata = 32'h0000_0000;
                    next_s.rresp = `MCS_RESP_SLVERR;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s <= mcs_pkg::MCS_CORE_RESET;
        end else begin
            s <= next_s;
        end
    end

    assign mem_addr = s.addr;
    assign data_bus_out = s.dout;
    assign data_bus_oe = s.doe;
    assign memory_read_strobe = s.rd;
    assign memory_write_strobe = s.wr;
    assign early_pulse = s.early;
    assign late_pulse = s.late;
    assign machine_state = s.st;
    assign io_select = s.io_sel;
    assign output_flag = s.output_flag;
    assign bvalid = s.bvalid;
    assign bresp = s.bresp;
    assign rvalid = s.rvalid;
    assign rdata = s.rdata;
    assign rresp = s.rresp;

    // =================================================================
    // checks
    default clocking dc @(posedge aclk); endclocking
    default disable iff (!aresetn);

    reset_jam_a: assert property ($rose(aresetn) |-> s.st == mcs_pkg::execute_state
        && s.upper_opcode_half == 4'h0 && s.low_code_field == 4'h0 && !s.output_flag
        && s.operand_pointer_select == 4'h0 && s.counter_choice == 4'h0)
        else $error("reset did not clear the control fields");
    reset_pulses_a: assert property ($rose(aresetn) |-> s.irq_accept_flag
        && !early_pulse && !late_pulse)
        else $error("reset left pulses or interrupt accept wrong");
    init_zero_a: assert property ($rose(aresetn) |=>
        (data_bus_oe && data_bus_out == 8'h00 && !memory_read_strobe) [*4])
        else $error("init cycle did not drive zero");
    idle_read_a: assert property (s.st == mcs_pkg::execute_state && s.idle
        && s.ph == `MCS_PH_LATE |-> memory_read_strobe && !data_bus_oe)
        else $error("idle cycle not reading memory");
    load_wait_a: assert property (s.load_mode && s.st == mcs_pkg::execute_state
        && end_cycle && !dma_in_req && !dma_out_req |=> s.st == mcs_pkg::execute_state
        ##1 !early_pulse)
        else $error("load mode left execute without DMA");
    dma_prio_a: assert property (end_cycle && dma_in_req && dma_out_req
        && (s.st == mcs_pkg::execute_state || s.st == mcs_pkg::dma_state)
        |=> s.st == mcs_pkg::dma_state && s.dma_in_cyc)
        else $error("DMA-in did not win");
    shift_right_a: assert property (exec_op && end_cycle
        && s.upper_opcode_half == `MCS_GRP_ALU && s.low_code_field == `MCS_SHIFT_RIGHT_OP
        |-> !data_bus_oe ##1 s.accumulator == ($past(s.accumulator) >> 1)
        && s.carry_flag == ^($past(s.accumulator) & 8'h01))
        else $error("shift right result wrong");
    dma_write_a: assert property (s.st == mcs_pkg::dma_state && s.dma_in_cyc
        && s.ph == `MCS_PH_LATE |-> memory_write_strobe && !data_bus_oe && !memory_read_strobe)
        else $error("DMA-in cycle not writing");
    irq_entry_a: assert property (s.st == mcs_pkg::irq_state && end_cycle
        |=> s.operand_pointer_select == `MCS_IRQ_X && s.counter_choice == `MCS_IRQ_P
        && !s.irq_accept_flag && s.st == mcs_pkg::fetch_state
        && s.pushed_pair_hold == {$past(s.operand_pointer_select), $past(s.counter_choice)})
        else $error("interrupt entry wrong");
    fetch_exec_a: assert property (s.st == mcs_pkg::fetch_state && end_cycle
        |=> s.st == mcs_pkg::execute_state)
        else $error("fetch not followed by execute");
    float_inc_a: assert property (exec_op && s.upper_opcode_half == `MCS_GRP_INC
        && s.ph == `MCS_PH_LATE |-> !memory_read_strobe && !data_bus_oe)
        else $error("increment cycle touched the bus");
    bresp_hold_a: assert property (bvalid && !bready |=> bvalid && $stable(bresp))
        else $error("write response dropped");

    cover_dma_in_c: cover property (s.st == mcs_pkg::dma_state && s.dma_in_cyc);
    cover_dma_out_c: cover property (s.st == mcs_pkg::dma_state && !s.dma_in_cyc);
    cover_irq_c: cover property (s.st == mcs_pkg::irq_state ##4 s.st == mcs_pkg::fetch_state);
    cover_idle_c: cover property (s.idle && s.st == mcs_pkg::execute_state);
endmodule

`default_nettype wire

// ---- test_machine_cycle_bus_sequencer.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "mcs_defs.svh"
module test_machine_cycle_bus_sequencer;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
    logic dma_in_req = 1'b0, dma_out_req = 1'b0, irq_req = 1'b0;
    logic [`MCS_AXI_AW-1:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rdata, rd;
    logic [3:0] wstrb = 4'hF, machine_state;
    logic [1:0] bresp, rresp, rs;
    logic awready, wready, bvalid, arready, rvalid, data_bus_oe, output_flag;
    logic memory_read_strobe, memory_write_strobe, early_pulse, late_pulse;
    logic [7:0] data_bus_out, data_bus_in;
    logic [15:0] mem_addr;
    logic [2:0] io_select;
    int error_cnt = 0, checks = 0;
    logic [2:0] io_seen = 3'h0;
    always #10 aclk = ~aclk;
    always @(posedge aclk) if (io_select != 3'h0) io_seen <= io_select;
    mcs_sequencer u_mcs_sequencer (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
        .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
        .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
        .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
        .rresp(rresp), .mem_addr(mem_addr), .data_bus_out(data_bus_out),
        .data_bus_oe(data_bus_oe), .data_bus_in(data_bus_in),
        .memory_read_strobe(memory_read_strobe), .memory_write_strobe(memory_write_strobe),
        .early_pulse(early_pulse), .late_pulse(late_pulse), .machine_state(machine_state),
        .io_select(io_select), .output_flag(output_flag), .dma_in_req(dma_in_req),
        .dma_out_req(dma_out_req), .irq_req(irq_req));
    mcs_mem_model u_mcs_mem_model (.aclk(aclk), .mem_addr(mem_addr),
        .data_bus_out(data_bus_out), .data_bus_oe(data_bus_oe),
        .memory_read_strobe(memory_read_strobe), .memory_write_strobe(memory_write_strobe),
        .machine_state(machine_state), .data_bus_in(data_bus_in));
    // ====================
    // tasks
    task automatic chk(input string what, input logic [33:0] exp, input logic [33:0] got);
        checks++;
        if (got !== exp) begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask
    // ready is sampled ahead of the edge so the release never races the slave
    task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ta, tw, tb;
        tb = 1'b0;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b0;
        // bready trails bvalid by a clock, so a held response is exercised
        while (!tb) begin
            @(negedge aclk);
            ta = awready && awvalid;
            tw = wready && wvalid;
            tb = bvalid && bready;
            r = bresp;
            @(posedge aclk);
            if (ta) awvalid <= 1'b0;
            if (tw) wvalid <= 1'b0;
            bready <= bvalid;
        end
    endtask
    task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        logic ta, tr;
        tr = 1'b0;
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        while (!tr) begin
            @(negedge aclk);
            ta = arready && arvalid;
            tr = rvalid;
            d = rdata;
            r = rresp;
            @(posedge aclk);
            if (ta) arvalid <= 1'b0;
        end
    endtask
    // k: 0 any, 1 write strobe, 2 read strobe
    task automatic wt(input logic [3:0] st, input int k);
        for (int i = 0; i < 100; i++) begin
            @(negedge aclk);
            if (machine_state === st && (k == 0 || (k == 1 ? memory_write_strobe
                : memory_read_strobe) === 1'b1)) return;
        end
        chk("state wait", 1, 0);
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", checks, error_cnt);
        if (error_cnt == 0 && checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    // ====================
    // tests
    initial begin
        repeat (12) @(posedge aclk);
        chk("reset state", 4'h2, machine_state);
        chk("reset pulses", 0, {early_pulse, late_pulse});
        aresetn <= 1'b1;
        @(posedge aclk);
        @(negedge aclk);
        chk("init bus", 9'h100, {data_bus_oe, data_bus_out});
        repeat (60) @(posedge aclk);
        axr(`MCS_CORE_OFF, rd, rs);
        chk("accumulator", 8'h2D, rd[23:16]);
        axr(`MCS_STAT_OFF, rd, rs);
        chk("carry accept", 2'h3, rd[9:8]);
        chk("idle", 1, rd[11]);
        chk("idle address", 16'h0007, mem_addr);
        chk("io select", 3'h1, io_seen);
        chk("output flag", 1, output_flag);
        $display("test program done");
        dma_in_req <= 1'b1;
        dma_out_req <= 1'b1;
        wt(4'h4, 1);
        chk("dma in address", 16'h0007, mem_addr);
        @(posedge aclk);
        dma_in_req <= 1'b0;
        wt(4'h4, 2);
        chk("dma out address", 16'h0008, mem_addr);
        @(posedge aclk);
        dma_out_req <= 1'b0;
        chk("dma byte", 8'hC3, u_mcs_mem_model.mem[7]);
        $display("test dma done");
        repeat (20) @(posedge aclk);
        irq_req <= 1'b1;
        wt(4'h8, 0);
        @(posedge aclk);
        irq_req <= 1'b0;
        wt(4'h1, 0);
        axr(`MCS_CORE_OFF, rd, rs);
        chk("irq pointers", 16'h0021, {rd[31:24], rd[7:0]});
        axw(8'h40, 32'h1, rs);
        chk("unmapped write", 2'h2, rs);
        axr(8'h40, rd, rs);
        chk("unmapped read", 34'h200000000, {rs, rd});
        axw(`MCS_CTRL_OFF, 32'h1, rs);
        axr(`MCS_STAT_OFF, rd, rs);
        chk("load mode", 1, rd[6]);
        $display("test irq and registers done");
        results;
    end
    initial begin
        #60000;
        error_cnt++;
        results;
    end
endmodule
`default_nettype wire
